/* hw/mia_params.svh */
// mia_params.svh: offsets, field positions, reset values and counts
// of the maskable interrupt arbiter; included by its bare name.
`ifndef MIA_PARAMS_SVH
`define MIA_PARAMS_SVH

// register offsets on the plain register port
`define MIA_OFS_PEND_LO 4'h0
`define MIA_OFS_PEND_HI 4'h1
`define MIA_OFS_EN_LO 4'h2
`define MIA_OFS_EN_HI 4'h3
`define MIA_OFS_STATUS 4'h4

// status register fields
`define MIA_ST_GIE_BIT 0
`define MIA_ST_NMI_BIT 1
`define MIA_ST_TRAP_BIT 2

// reset values
`define MIA_RST_BYTE 8'h00
`define MIA_RST_SRC 14'h0000

// acknowledge sequence, in instruction cycles (one sys_clk each)
`define MIA_ACK_INSTR_CYCLES 7
`define MIA_ACK_LAST 3'(`MIA_ACK_INSTR_CYCLES - 1)
`define MIA_ACK_PUSH_STEP 3'h1

// addresses and vector slot offsets (low byte within the vector block)
`define MIA_ENTRY_ADDR 15'h00ff
`define MIA_VEC_TRAP 8'hfe
`define MIA_VEC_DEFAULT 8'he0
`define MIA_VEC_BASE 8'he2

`endif

/* hw/mia_pkg.sv */
// mia_pkg: types of the maskable interrupt arbiter.
// assumes mia_params.svh is compiled alongside.
package mia_pkg;

  // number of maskable sources; index 13 ranks highest, 0 lowest
  localparam int MIA_NUM_SRC = 14;

  typedef logic [MIA_NUM_SRC-1:0] mia_src_t;

  // address with a one-cycle valid, used for push and pc load
  typedef struct packed {
    logic valid;
    logic [14:0] addr;
  } mia_addr_s;

  // result of the fixed-priority encoder
  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } mia_pick_s;

  typedef enum logic {MIA_IDLE, MIA_ACK} mia_state_e;

endpackage

/* hw/mia_arbiter.sv */
// mia_arbiter: interrupt control of an 8-bit core: pending and enable
// bits, global enable, fixed-priority arbitration, acknowledge sequence.
// assumes one sys_clk edge per instruction cycle tick, and a sequencer
// that stalls while ack_busy is high and answers pops one cycle later.
//
// Functional notes
// - software trap ignores all enables; other sources need own enable and global
// - fixed priority: trap highest, default vector lowest
// - fourteen maskable sources, each with fixed rank and vector slot
// - pending flag sets on its event regardless of enable
// - maskable request fires only with pending, enable and global enable set
// - while trap routine runs, maskable requests wait until it returns
// - requests are evaluated only at instruction start
// - simultaneous requests: highest rank served, rest stay pending
// - reset clears pending, enables and global enable
// - enabling a source already pending fires at next boundary
// - a pending skip is performed before acknowledge
// - acknowledge clears the global enable
// - acknowledge pushes the address about to execute
// - acknowledge loads program counter with 00ff hex
// - acknowledge sequence lasts seven instruction cycles
// - software may set global enable in status word to allow nesting
// - return sets global enable, pops address, loads program counter
// - remaining requests are served right after the return
// - pending and enable bits are readable and writable by software
// - trap vector sits at the top slot, offsets fe and ff
// - lookup with nothing active returns the default vector
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mia_params.svh"

module mia_arbiter import mia_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral events
  input wire logic [MIA_NUM_SRC-1:0] irq_event,
  input wire logic trap_event,
  // core sequencer
  input wire logic instr_start,
  input wire logic skip_next,
  input wire logic [14:0] pc_current,
  input wire logic return_from_irq,
  input wire logic vis_exec,
  input wire logic [14:0] stack_pop_data,
  input wire logic stack_pop_valid,
  // to core sequencer and stack
  output logic ack_busy,
  output var mia_addr_s stack_push,
  output logic stack_pop_req,
  output var mia_addr_s pc_load,
  output logic vis_valid,
  output logic [7:0] vis_vector,
  output logic global_irq_enable,
  output logic nmi_active
);

  // highest set bit of the active sources
  function automatic mia_pick_s pick(input mia_src_t act);
    mia_pick_s p;
    p = '0;
    for (int i = 0; i < MIA_NUM_SRC; i++) begin
      if (act[i]) begin
        p.hit = 1'b1;
        p.idx = 4'(i);
      end
    end
    return p;
  endfunction

  mia_src_t pend_q, pend_d, en_q, en_d, active;
  logic gie_q, trap_pend_q, nmi_q;
  mia_state_e state_q;
  logic [2:0] step_q;
  logic [14:0] ret_addr_q;
  logic [7:0] rdata_q, vis_vec_q;
  logic vis_valid_q, pop_req_q;
  mia_addr_s push_q, load_q;
  mia_pick_s best;
  logic boundary, take_trap, take_mask, take;

  // per-source active term and winner
  assign active = pend_q & en_q;
  assign best = pick(active);

  // evaluation at instruction start only, after any skip
  assign boundary = instr_start && !skip_next && state_q == MIA_IDLE;
  assign take_trap = boundary && trap_pend_q;
  assign take_mask = boundary && !nmi_q && gie_q && best.hit;
  assign take = take_trap || take_mask;

  // next pending and enable values: event set wins over a write
  always_comb begin
    pend_d = pend_q;
    en_d = en_q;
    if (reg_wr && reg_addr == `MIA_OFS_PEND_LO) begin
      pend_d[7:0] = reg_wdata;
    end else if (reg_wr && reg_addr == `MIA_OFS_PEND_HI) begin
      pend_d[13:8] = reg_wdata[5:0];
    end else if (reg_wr && reg_addr == `MIA_OFS_EN_LO) begin
      en_d[7:0] = reg_wdata;
    end else if (reg_wr && reg_addr == `MIA_OFS_EN_HI) begin
      en_d[13:8] = reg_wdata[5:0];
    end
    pend_d = pend_d | irq_event;
  end

  // pending and enable registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_q <= `MIA_RST_SRC;
      en_q <= `MIA_RST_SRC;
    end else begin
      pend_q <= pend_d;
      en_q <= en_d;
    end
  end

  // global enable: ack clears, return sets, status writes load bit 0
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gie_q <= 1'b0;
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (return_from_irq) begin
      gie_q <= 1'b1;
    end else if (reg_wr && reg_addr == `MIA_OFS_STATUS) begin
      gie_q <= reg_wdata[`MIA_ST_GIE_BIT];
    end
  end

  // trap pending and in-service state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trap_pend_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      trap_pend_q <= trap_event || (trap_pend_q && !take_trap);
      if (take_trap) begin
        nmi_q <= 1'b1;
      end else if (return_from_irq) begin
        nmi_q <= 1'b0;
      end
    end
  end

  // acknowledge sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= MIA_IDLE;
      step_q <= 3'h0;
      ret_addr_q <= 15'h0000;
    end else begin
      case (state_q)
        MIA_IDLE: begin
          step_q <= 3'h0;
          if (take) begin
            state_q <= MIA_ACK;
            ret_addr_q <= pc_current;
          end
        end
        MIA_ACK: begin
          step_q <= step_q + 3'h1;
          if (step_q == `MIA_ACK_LAST) begin
            state_q <= MIA_IDLE;
          end
        end
        default: state_q <= MIA_IDLE;
      endcase
    end
  end

  // busy, push and program counter load outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_busy <= 1'b0;
      push_q <= '0;
      load_q <= '0;
    end else begin
      if (take) begin
        ack_busy <= 1'b1;
      end else if (state_q == MIA_ACK && step_q == `MIA_ACK_LAST) begin
        ack_busy <= 1'b0;
      end
      push_q.valid <= state_q == MIA_ACK && step_q == `MIA_ACK_PUSH_STEP;
      push_q.addr <= ret_addr_q;
      if (state_q == MIA_ACK && step_q == `MIA_ACK_LAST) begin
        load_q <= {1'b1, `MIA_ENTRY_ADDR};
      end else if (stack_pop_valid) begin
        load_q <= {1'b1, stack_pop_data};
      end else begin
        load_q.valid <= 1'b0;
      end
    end
  end

  // return pops the saved address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pop_req_q <= 1'b0;
    end else begin
      pop_req_q <= return_from_irq;
    end
  end

  // vector-select lookup
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vis_valid_q <= 1'b0;
      vis_vec_q <= `MIA_VEC_DEFAULT;
    end else begin
      vis_valid_q <= vis_exec;
      if (vis_exec) begin
        if (nmi_q || trap_pend_q) begin
          vis_vec_q <= `MIA_VEC_TRAP;
        end else if (best.hit) begin
          vis_vec_q <= `MIA_VEC_BASE + {3'h0, best.idx, 1'b0};
        end else begin
          vis_vec_q <= `MIA_VEC_DEFAULT;
        end
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= `MIA_RST_BYTE;
    end else if (!reg_rd) begin
      rdata_q <= 8'h00;
    end else if (reg_addr == `MIA_OFS_PEND_LO) begin
      rdata_q <= pend_q[7:0];
    end else if (reg_addr == `MIA_OFS_PEND_HI) begin
      rdata_q <= {2'h0, pend_q[13:8]};
    end else if (reg_addr == `MIA_OFS_EN_LO) begin
      rdata_q <= en_q[7:0];
    end else if (reg_addr == `MIA_OFS_EN_HI) begin
      rdata_q <= {2'h0, en_q[13:8]};
    end else if (reg_addr == `MIA_OFS_STATUS) begin
      rdata_q <= {5'h00, trap_pend_q, nmi_q, gie_q};
    end else begin
      rdata_q <= 8'h00; // unmapped
    end
  end

  assign reg_rdata = rdata_q;
  assign stack_push = push_q;
  assign pc_load = load_q;
  assign stack_pop_req = pop_req_q;
  assign vis_valid = vis_valid_q;
  assign vis_vector = vis_vec_q;
  assign global_irq_enable = gie_q;
  assign nmi_active = nmi_q;

  // checks
  property p_trap_unmasked;
    @(posedge sys_clk) disable iff (reset)
    (instr_start && !skip_next && !ack_busy && trap_pend_q) |=> ack_busy;
  endproperty
  a_trap_unmasked: assert property (p_trap_unmasked)
    else $error("trap not acknowledged at boundary");

  property p_mask_fire;
    @(posedge sys_clk) disable iff (reset)
    (instr_start && !skip_next && !ack_busy && !nmi_q && gie_q
      && (pend_q & en_q) != '0) |=> ack_busy && !global_irq_enable;
  endproperty
  a_mask_fire: assert property (p_mask_fire)
    else $error("qualified request not acknowledged");

  property p_nmi_hold;
    @(posedge sys_clk) disable iff (reset)
    (!ack_busy && nmi_q && !trap_pend_q) |=> !ack_busy;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold)
    else $error("maskable taken during trap routine");

  property p_boundary_only;
    @(posedge sys_clk) disable iff (reset)
    (!ack_busy && (!instr_start || skip_next)) |=> !ack_busy;
  endproperty
  a_boundary_only: assert property (p_boundary_only)
    else $error("acknowledge away from boundary or during skip");

  property p_pend_set;
    @(posedge sys_clk) disable iff (reset)
    irq_event != '0 |=> (pend_q & $past(irq_event)) == $past(irq_event);
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("event lost");

  property p_reset_clear;
    @(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> pend_q == '0 && en_q == '0 && !gie_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");

  property p_ack_len;
    @(posedge sys_clk) disable iff (reset)
    $rose(ack_busy) |-> !global_irq_enable && ack_busy [*7] ##1 !ack_busy;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge length wrong");

  property p_push;
    @(posedge sys_clk) disable iff (reset)
    $rose(ack_busy) |-> ##2 stack_push.valid
      && stack_push.addr == $past(pc_current, 3);
  endproperty
  a_push: assert property (p_push)
    else $error("return address not pushed");

  property p_entry;
    @(posedge sys_clk) disable iff (reset)
    $rose(ack_busy) |-> ##7 pc_load.valid && pc_load.addr == `MIA_ENTRY_ADDR;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry address not loaded");

  property p_return_from_irq;
    @(posedge sys_clk) disable iff (reset)
    (return_from_irq && !take) |=> global_irq_enable && stack_pop_req;
  endproperty
  a_return_from_irq: assert property (p_return_from_irq)
    else $error("return did not set enable or pop");

  property p_vis_default;
    @(posedge sys_clk) disable iff (reset)
    (vis_exec && !nmi_q && !trap_pend_q && (pend_q & en_q) == '0)
      |=> vis_valid && vis_vector == `MIA_VEC_DEFAULT;
  endproperty
  a_vis_default: assert property (p_vis_default)
    else $error("default vector not returned");

  // a trap, pending or in service, always wins the lookup
  property p_trap_vec;
    @(posedge sys_clk) disable iff (reset)
    (vis_exec && (nmi_q || trap_pend_q))
      |=> vis_valid && vis_vector == `MIA_VEC_TRAP;
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap vector not returned");

  // a status write reaches the global enable unless ack or return beat it
  property p_gie_write;
    @(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == `MIA_OFS_STATUS && !take && !return_from_irq)
      |=> global_irq_enable == $past(reg_wdata[`MIA_ST_GIE_BIT]);
  endproperty
  a_gie_write: assert property (p_gie_write)
    else $error("status write did not reach global enable");

  // the popped address goes to the program counter one cycle later
  property p_ret_load;
    @(posedge sys_clk) disable iff (reset)
    (stack_pop_valid && !ack_busy)
      |=> pc_load.valid && pc_load.addr == $past(stack_pop_data);
  endproperty
  a_ret_load: assert property (p_ret_load)
    else $error("popped address not loaded");

  c_mask_ack: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(ack_busy) && !nmi_q);
  c_trap_ack: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(nmi_q));
  c_vis_hit: cover property (@(posedge sys_clk) disable iff (reset)
    vis_valid && vis_vector != `MIA_VEC_DEFAULT);
  c_return: cover property (@(posedge sys_clk) disable iff (reset)
    stack_pop_req ##1 pc_load.valid);

endmodule

`default_nettype wire

/* verif/mia_stack_model.sv */
// mia_stack_model: return-address stack beside the core sequencer.
// assumes pushes and pop requests arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module mia_stack_model import mia_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // from the arbiter
  input wire mia_addr_s stack_push,
  input wire logic stack_pop_req,
  // back to the arbiter
  output logic [14:0] stack_pop_data,
  output logic stack_pop_valid
);
  logic [14:0] mem_q [0:7];
  logic [2:0] sp_q;
  // push on valid, answer a pop one cycle later
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sp_q <= 3'h0;
      stack_pop_valid <= 1'b0;
      stack_pop_data <= 15'h0000;
    end else begin
      stack_pop_valid <= stack_pop_req;
      if (stack_push.valid) begin
        mem_q[sp_q] <= stack_push.addr;
        sp_q <= sp_q + 3'h1;
      end
      if (stack_pop_req) begin
        stack_pop_data <= mem_q[sp_q - 3'h1];
        sp_q <= sp_q - 3'h1;
      end else begin
        stack_pop_data <= ~stack_pop_data; // stale data keeps moving
      end
    end
  end
endmodule
`default_nettype wire

/* verif/mia_arbiter_tb.sv */
// mia_arbiter_tb: self-checking bench of the interrupt arbiter.
// assumes the arbiter and the stack model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "mia_params.svh"
module mia_arbiter_tb import mia_pkg::*;;
  logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, vis_vector;
  logic [13:0] irq_event = 14'h0000;
  logic trap_event = 1'b0, instr_start = 1'b0, skip_next = 1'b0;
  logic return_from_irq = 1'b0, vis_exec = 1'b0, stack_pop_valid;
  logic [14:0] pc_current = 15'h0000, stack_pop_data;
  logic ack_busy, stack_pop_req, vis_valid, global_irq_enable, nmi_active;
  mia_addr_s stack_push, pc_load;
  int miscompares = 0, comparisons = 0;
  logic [7:0] rv;
  // clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  mia_arbiter dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_event(irq_event), .trap_event(trap_event),
    .instr_start(instr_start), .skip_next(skip_next),
    .pc_current(pc_current), .return_from_irq(return_from_irq),
    .vis_exec(vis_exec), .stack_pop_data(stack_pop_data),
    .stack_pop_valid(stack_pop_valid), .ack_busy(ack_busy),
    .stack_push(stack_push), .stack_pop_req(stack_pop_req),
    .pc_load(pc_load), .vis_valid(vis_valid), .vis_vector(vis_vector),
    .global_irq_enable(global_irq_enable), .nmi_active(nmi_active));
  mia_stack_model stk (.sys_clk(sys_clk), .reset(reset),
    .stack_push(stack_push), .stack_pop_req(stack_pop_req),
    .stack_pop_data(stack_pop_data), .stack_pop_valid(stack_pop_valid));
  // compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // register bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // one-cycle pulses of events
  task automatic ev(input logic [13:0] m, input logic t);
    @(posedge sys_clk) begin irq_event <= m; trap_event <= t; end
    @(posedge sys_clk) begin irq_event <= 14'h0000; trap_event <= 1'b0; end
  endtask
  // vector lookup and its answer
  task automatic vector_select_instruction(input logic [7:0] exp);
    @(posedge sys_clk) vis_exec <= 1'b1;
    @(posedge sys_clk) vis_exec <= 1'b0;
    #1 check(vis_valid, 1'b1);
    check(vis_vector, exp);
  endtask
  // instruction boundary, then walk the eight cycles after it
  task automatic bnd(input logic [14:0] pc, input logic skip, input logic ack);
    @(posedge sys_clk) begin
      instr_start <= 1'b1; pc_current <= pc; skip_next <= skip;
    end
    @(posedge sys_clk) begin instr_start <= 1'b0; skip_next <= 1'b0; end
    #1;
    for (int i = 1; i <= 8; i++) begin
      check(ack_busy, ack && i <= 7);
      check(stack_push.valid, ack && i == 3);
      check(pc_load.valid, ack && i == 8);
      if (ack && i == 1) check(global_irq_enable, 1'b0);
      if (ack && i == 3) check(stack_push.addr, pc);
      if (ack && i == 8) check(pc_load.addr, `MIA_ENTRY_ADDR);
      @(posedge sys_clk) #1;
    end
  endtask
  // return, pop, and reload of the saved address
  task automatic ret(input logic [14:0] pc);
    int n;
    @(posedge sys_clk) return_from_irq <= 1'b1;
    @(posedge sys_clk) return_from_irq <= 1'b0;
    #1 check(global_irq_enable, 1'b1);
    check(stack_pop_req, 1'b1);
    check(nmi_active, 1'b0);
    n = 0;
    while (pc_load.valid !== 1'b1) begin
      if (++n > 8) begin
        check(1'b0, 1'b1);
        close_out();
      end
      @(posedge sys_clk) #1;
    end
    check(pc_load.addr, pc);
  endtask
  // reset values, unmapped place, masked request
  task automatic t_reset();
    for (int a = 0; a <= 5; a++) begin
      rd(4'(a), rv);
      check(rv, 8'h00);
    end
    check(vis_vector, 8'he0);
    ev(14'h0008, 1'b0);
    rd(`MIA_OFS_PEND_LO, rv);
    check(rv, 8'h08);
    wr(`MIA_OFS_EN_HI, 8'hff);
    rd(`MIA_OFS_EN_HI, rv);
    check(rv, 8'h3f);
    wr(`MIA_OFS_EN_HI, 8'h00);
    bnd(15'h0123, 1'b0, 1'b0);
    vector_select_instruction(8'he0);
    wr(`MIA_OFS_EN_LO, 8'h08);
    vector_select_instruction(8'he8);
  endtask
  // late enable, acknowledge, return, and service of what remains
  task automatic t_ack();
    wr(`MIA_OFS_STATUS, 8'h01);
    rd(`MIA_OFS_STATUS, rv);
    check(rv, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1 check(ack_busy, 1'b0);
    bnd(15'h1234, 1'b0, 1'b1);
    ret(15'h1234);
    bnd(15'h2345, 1'b1, 1'b0);
    bnd(15'h2346, 1'b0, 1'b1);
    ret(15'h2346);
  endtask
  // two sources at once: higher rank first, lower stays pending
  task automatic t_prio();
    ev(14'h0400, 1'b0);
    wr(`MIA_OFS_EN_HI, 8'h04);
    vector_select_instruction(8'hf6);
    bnd(15'h0100, 1'b0, 1'b1);
    wr(`MIA_OFS_PEND_HI, 8'h00);
    rd(`MIA_OFS_PEND_LO, rv);
    check(rv, 8'h08);
    vector_select_instruction(8'he8);
    ret(15'h0100);
  endtask
  // software trap ignores enables and holds maskable requests off
  task automatic t_trap();
    wr(`MIA_OFS_STATUS, 8'h00);
    ev(14'h0000, 1'b1);
    rd(`MIA_OFS_STATUS, rv);
    check(rv, 8'h04);
    vector_select_instruction(8'hfe);
    bnd(15'h0200, 1'b0, 1'b1);
    check(nmi_active, 1'b1);
    vector_select_instruction(8'hfe);
    wr(`MIA_OFS_STATUS, 8'h01);
    bnd(15'h0300, 1'b0, 1'b0);
    ret(15'h0200);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_ack();
    t_prio();
    t_trap();
    close_out();
  end
endmodule
`default_nettype wire
